/* File: hdl/agp_map.svh */
// Named constants for the strobe port: timing counts, idle levels and widths.
`ifndef AGP_MAP_SVH
`define AGP_MAP_SVH

// Core clock cycles spent on one data word at each rate.
`define AGP_WORD_2X     8'h04
`define AGP_WORD_4X     8'h02
// Cycles the strobes stay driven at their last level after the final word.
`define AGP_PARK_CYC    8'h02
// First value of the word and park counters, and their count step.
`define AGP_CNT_ZERO    8'h00
`define AGP_CNT_ONE     8'h01
// Levels of a strobe pair while idle.
`define AGP_STB_IDLE    1'b0
`define AGP_STBN_IDLE   1'b1
// Output enables are active low.
`define AGP_OE_ON       1'b0
`define AGP_OE_OFF      1'b1
// Bus widths.
`define AGP_AD_W        32
`define AGP_BE_W        4
`define AGP_SBA_W       8
`define AGP_LANES       2

`endif

/* File: hdl/agp_pkg.sv */
// Types shared by the strobe port design.
package agp_pkg;

    // Transmit sequencer states, Gray coded along idle, drive, park.
    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_DRIVE = 2'b01,
        TX_PARK  = 2'b11
    } agp_tx_state_e;

    typedef logic [7:0] agp_cnt_t;

endpackage : agp_pkg

/* File: hdl/agp_fifo.sv */
// Single clock FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module agp_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // *****************************************************************
    // Storage and pointers
    // *****************************************************************
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             do_wr;
    logic             do_rd;

    // The pointers carry one extra bit so full and empty are told apart.
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("agp_fifo: DEPTH must be a power of two, at least 2.");
        end
    end

    // Full when the pointers differ only in the wrap bit.
    assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid = (wr_ptr != rd_ptr);
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;

    // Write side.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= '0;
        end else if (do_wr) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    // Memory has no reset so it can map to plain storage.
    always_ff @(posedge clock) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // Read side.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_ptr <= '0;
        end else if (do_rd) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end

    assign out_data = mem[rd_ptr[AW-1:0]];

endmodule : agp_fifo

`default_nettype wire

/* File: hdl/agp_strobe_port.sv */
// Source synchronous strobe port: AD transmit with strobes, sideband receive.
//
// Functional notes
// - Source drives strobe 0 for lower lanes.
// - Source drives strobe 1 for upper lanes.
// - Source drives strobe 0 complement as pair.
// - Strobe 1 complement driven in 4x only.
`timescale 1ns/1ps
`default_nettype none
`include "agp_map.svh"

module agp_strobe_port #(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic                    clock,
    input  wire logic                    nrst,
    input  wire logic                    link_clock,
    input  wire logic                    tx_valid,
    output logic                         tx_ready,
    input  wire logic [`AGP_AD_W-1:0]    tx_data,
    input  wire logic [`AGP_BE_W-1:0]    tx_be_n,
    input  wire logic                    src_grant,
    input  wire logic                    rate_4x,
    output logic                         tx_busy,
    output logic      [`AGP_AD_W-1:0]    ad_o,
    output logic                         ad_oe_n,
    output logic      [`AGP_BE_W-1:0]    cbe_n_o,
    output logic      [`AGP_LANES-1:0]   adstb_o,
    output logic      [`AGP_LANES-1:0]   adstb_oe_n,
    output logic      [`AGP_LANES-1:0]   adstb_n_o,
    output logic      [`AGP_LANES-1:0]   adstb_n_oe_n,
    input  wire logic                    sb_enable,
    input  wire logic [`AGP_SBA_W-1:0]   sba,
    output logic                         sb_valid,
    output logic      [`AGP_SBA_W-1:0]   sb_addr
);
    localparam int FW = `AGP_AD_W + `AGP_BE_W;

    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("agp_strobe_port: FIFO_DEPTH must be at least 2.");
        end
    end

    // *****************************************************************
    // Transmit buffer
    // *****************************************************************
    logic          fifo_valid;
    logic          fifo_ready;
    logic [FW-1:0] fifo_data;

    // The buffer absorbs bursts while the port waits for its grant;
    // tx_ready falls when it is full, stalling the source.
    agp_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .nrst      (nrst),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   ({tx_be_n, tx_data}),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_data)
    );

    // *****************************************************************
    // Transmit sequencer
    // *****************************************************************
    agp_pkg::agp_tx_state_e state;
    agp_pkg::agp_cnt_t      cnt;
    logic                   rate_q;
    logic                   stb;
    logic                   stb_n;
    agp_pkg::agp_cnt_t      word_len;
    agp_pkg::agp_cnt_t      word_half;
    logic                   word_end;
    logic                   load_word;

    // Word length follows the rate latched at the start of a burst.
    assign word_len  = rate_q ? `AGP_WORD_4X : `AGP_WORD_2X;
    assign word_half = word_len >> 1;
    assign word_end  = (state == agp_pkg::TX_DRIVE) && (cnt == word_len - `AGP_CNT_ONE);

    // A word is taken when a burst starts or when the last one has run out.
    assign load_word = src_grant && fifo_valid &&
                       ((state == agp_pkg::TX_IDLE) || word_end);
    assign fifo_ready = load_word;

    // State transitions: a burst ends when the grant or the data runs out.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= agp_pkg::TX_IDLE;
        end else begin
            unique case (state)
                agp_pkg::TX_IDLE: begin
                    if (load_word) begin
                        state <= agp_pkg::TX_DRIVE;
                    end
                end
                agp_pkg::TX_DRIVE: begin
                    if (word_end && !load_word) begin
                        state <= agp_pkg::TX_PARK;
                    end
                end
                agp_pkg::TX_PARK: begin
                    if (cnt == `AGP_PARK_CYC - `AGP_CNT_ONE) begin
                        state <= agp_pkg::TX_IDLE;
                    end
                end
                default: begin
                    state <= agp_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // Word and park cycle counter.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt <= `AGP_CNT_ZERO;
        end else if (load_word || word_end || state == agp_pkg::TX_IDLE) begin
            cnt <= `AGP_CNT_ZERO;
        end else begin
            cnt <= cnt + `AGP_CNT_ONE;
        end
    end

    // The rate is frozen for the whole burst so strobe timing never
    // changes in the middle of a word.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rate_q <= 1'b0;
        end else if (state == agp_pkg::TX_IDLE && load_word) begin
            rate_q <= rate_4x;
        end
    end

    // Data and byte enables are launched at the start of each word.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ad_o    <= '0;
            cbe_n_o <= '1;
        end else if (load_word) begin
            ad_o    <= fifo_data[`AGP_AD_W-1:0];
            cbe_n_o <= fifo_data[FW-1:`AGP_AD_W];
        end
    end

    // Strobes flip in mid word so the receiver samples a settled value;
    // the complement is a flop of its own to keep the pair skew small.
    // The pair parks as the enables drop, so a burst that starts in the
    // first idle cycle never opens with a stray edge on a driven strobe.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stb   <= `AGP_STB_IDLE;
            stb_n <= `AGP_STBN_IDLE;
        end else if (state == agp_pkg::TX_DRIVE && cnt == word_half - `AGP_CNT_ONE) begin
            stb   <= ~stb;
            stb_n <= stb;
        end else if (state == agp_pkg::TX_PARK && cnt == `AGP_PARK_CYC - `AGP_CNT_ONE) begin
            stb   <= `AGP_STB_IDLE;
            stb_n <= `AGP_STBN_IDLE;
        end
    end

    // Output enables: data and strobes are driven from the first word
    // until the park time ends.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ad_oe_n      <= `AGP_OE_OFF;
            adstb_oe_n   <= {`AGP_LANES{`AGP_OE_OFF}};
            adstb_n_oe_n <= {`AGP_LANES{`AGP_OE_OFF}};
        end else if (state == agp_pkg::TX_IDLE && load_word) begin
            ad_oe_n         <= `AGP_OE_ON;
            adstb_oe_n      <= {`AGP_LANES{`AGP_OE_ON}};
            adstb_n_oe_n[0] <= `AGP_OE_ON;
            adstb_n_oe_n[1] <= rate_4x ? `AGP_OE_ON : `AGP_OE_OFF;
        end else if (state == agp_pkg::TX_PARK && cnt == `AGP_PARK_CYC - `AGP_CNT_ONE) begin
            ad_oe_n      <= `AGP_OE_OFF;
            adstb_oe_n   <= {`AGP_LANES{`AGP_OE_OFF}};
            adstb_n_oe_n <= {`AGP_LANES{`AGP_OE_OFF}};
        end
    end

    // Both lanes share one strobe source, so their edges are aligned.
    assign adstb_o   = {`AGP_LANES{stb}};
    assign adstb_n_o = {`AGP_LANES{stb_n}};
    assign tx_busy   = (state != agp_pkg::TX_IDLE);

    // *****************************************************************
    // Sideband receive, link clock domain
    // *****************************************************************
    logic                  sb_en_l1;
    logic                  sb_en_l2;
    logic [`AGP_SBA_W-1:0] sb_hold;
    logic                  sb_tgl;

    // The enable is a quasi static level and crosses by two flops.
    always_ff @(posedge link_clock or negedge nrst) begin
        if (!nrst) begin
            sb_en_l1 <= 1'b0;
            sb_en_l2 <= 1'b0;
        end else begin
            sb_en_l1 <= sb_enable;
            sb_en_l2 <= sb_en_l1;
        end
    end

    // One byte per rising strobe edge; the toggle marks it for the core side.
    // The hold register is overwritten by the next byte, so the core
    // must take each byte within one link period, which it does easily.
    always_ff @(posedge link_clock or negedge nrst) begin
        if (!nrst) begin
            sb_hold <= '0;
            sb_tgl  <= 1'b0;
        end else if (sb_en_l2) begin
            sb_hold <= sba;
            sb_tgl  <= ~sb_tgl;
        end
    end

    // *****************************************************************
    // Sideband receive, core clock domain
    // *****************************************************************
    logic sb_s1;
    logic sb_s2;
    logic sb_s3;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sb_s1 <= 1'b0;
            sb_s2 <= 1'b0;
            sb_s3 <= 1'b0;
        end else begin
            sb_s1 <= sb_tgl;
            sb_s2 <= sb_s1;
            sb_s3 <= sb_s2;
        end
    end

    // The byte has been stable for two core cycles when the toggle lands.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sb_valid <= 1'b0;
            sb_addr  <= '0;
        end else begin
            sb_valid <= sb_s2 ^ sb_s3;
            if (sb_s2 ^ sb_s3) begin
                sb_addr <= sb_hold;
            end
        end
    end

    // *****************************************************************
    // Assertions
    // *****************************************************************
    a_lanes_same_strobe: assert property (@(posedge clock) disable iff (!nrst)
        (adstb_o[0] == adstb_o[1]) && (adstb_oe_n[0] == adstb_oe_n[1]))
        else $error("Strobe lanes differ.");

    a_strobe_with_data: assert property (@(posedge clock) disable iff (!nrst)
        (ad_oe_n == adstb_oe_n[0]) && (ad_oe_n == adstb_n_oe_n[0]))
        else $error("Strobe enable does not follow data enable.");

    a_pair_complement: assert property (@(posedge clock) disable iff (!nrst)
        !adstb_n_oe_n[0] |-> (adstb_n_o[0] == !adstb_o[0]))
        else $error("Strobe 0 pair not complementary.");

    a_cmp1_only_4x: assert property (@(posedge clock) disable iff (!nrst)
        !adstb_n_oe_n[1] |-> rate_q)
        else $error("Strobe 1 complement driven outside 4x.");

    a_cmp1_driven_4x: assert property (@(posedge clock) disable iff (!nrst)
        (!adstb_oe_n[1] && rate_q) |-> !adstb_n_oe_n[1])
        else $error("Strobe 1 complement missing in 4x.");

    a_edge_per_word: assert property (@(posedge clock) disable iff (!nrst)
        (load_word && !rate_4x && state == agp_pkg::TX_IDLE) |-> ##3 (stb != $past(stb)))
        else $error("No strobe edge in mid word.");

    a_data_held_edge: assert property (@(posedge clock) disable iff (!nrst)
        (!ad_oe_n && $changed(stb)) |-> $stable(ad_o))
        else $error("Data changed on a strobe edge.");

    a_park_bounded: assert property (@(posedge clock) disable iff (!nrst)
        (state == agp_pkg::TX_PARK) |-> ##[1:2] (state == agp_pkg::TX_IDLE))
        else $error("Park lasted too long.");

    a_sb_gated: assert property (@(posedge link_clock) disable iff (!nrst)
        !sb_en_l2 |=> $stable(sb_tgl))
        else $error("Sideband byte taken while disabled.");

    c_burst_2x: cover property (@(posedge clock) disable iff (!nrst)
        (state == agp_pkg::TX_DRIVE && !rate_q && word_end) ##1 (state == agp_pkg::TX_PARK));

    c_burst_4x: cover property (@(posedge clock) disable iff (!nrst)
        (state == agp_pkg::TX_PARK && rate_q));

    c_fifo_full: cover property (@(posedge clock) disable iff (!nrst) !tx_ready);

    c_sb_byte: cover property (@(posedge clock) disable iff (!nrst) sb_valid);

endmodule : agp_strobe_port

`default_nettype wire

/* File: testbench/agp_master_model.sv */
// Behavioural graphics master that strobes bytes onto the sideband bus.
`timescale 1ns/1ps
`default_nettype none

module agp_master_model (
    output logic       link_clock,
    output logic       link_clock_n,
    output logic [7:0] sba
);
    // ****************************************************************
    // Idle levels
    // ****************************************************************
    // The strobe stands still between frames, so only sent bytes clock.
    initial begin
        link_clock   = 1'b0;
        link_clock_n = 1'b1;
        sba          = 8'h00;
    end

    // ****************************************************************
    // Byte transfer
    // ****************************************************************
    // One byte per rising strobe edge at a 45 ns period; the complement
    // runs as the differential partner; the bus then shows the inverse
    // for 15 ns so a stale value can never be captured by luck.
    task automatic send_byte(input logic [7:0] b);
        sba          = b;
        #15;
        link_clock   = 1'b1;
        link_clock_n = 1'b0;
        #15;
        link_clock   = 1'b0;
        link_clock_n = 1'b1;
        sba          = ~b;
        #15;
    endtask : send_byte
endmodule : agp_master_model

`default_nettype wire

/* File: testbench/tb_agp_strobe_port.sv */
// Self-checking bench for the strobe port and its sideband receiver.
`timescale 1ns/1ps
`default_nettype none
`include "agp_map.svh"

module tb_agp_strobe_port;
    logic        clock;
    logic        nrst;
    logic        link_clock;
    logic        link_clock_n;
    logic        tx_valid;
    logic        tx_ready;
    logic [31:0] tx_data;
    logic [3:0]  tx_be_n;
    logic        src_grant;
    logic        rate_4x;
    logic        tx_busy;
    logic [31:0] ad_o;
    logic        ad_oe_n;
    logic [3:0]  cbe_n_o;
    logic [1:0]  adstb_o;
    logic [1:0]  adstb_oe_n;
    logic [1:0]  adstb_n_o;
    logic [1:0]  adstb_n_oe_n;
    logic        sb_enable;
    logic [7:0]  sba;
    logic        sb_valid;
    logic [7:0]  sb_addr;
    logic        last_stb;
    int          fail_count;
    int          compares;
    int          sb_count = 0;

    agp_strobe_port agp_strobe_port_inst (
        .clock(clock), .nrst(nrst), .link_clock(link_clock),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_be_n(tx_be_n),
        .src_grant(src_grant), .rate_4x(rate_4x), .tx_busy(tx_busy),
        .ad_o(ad_o), .ad_oe_n(ad_oe_n), .cbe_n_o(cbe_n_o), .adstb_o(adstb_o),
        .adstb_oe_n(adstb_oe_n), .adstb_n_o(adstb_n_o), .adstb_n_oe_n(adstb_n_oe_n),
        .sb_enable(sb_enable), .sba(sba), .sb_valid(sb_valid), .sb_addr(sb_addr)
    );

    agp_master_model agp_master_model_inst (
        .link_clock(link_clock), .link_clock_n(link_clock_n), .sba(sba)
    );

    // ****************************************************************
    // Clock and helpers
    // ****************************************************************
    // Core clock at 200 MHz.
    initial clock = 1'b0;
    always #2.5 clock = ~clock;

    // Counts sideband bytes handed to the core side, sampled mid cycle.
    always @(negedge clock) begin
        if (sb_valid === 1'b1) begin
            sb_count <= sb_count + 1;
        end
    end

    task automatic end_sim();
        if (fail_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : check

    // Holds tx_valid up across calls so back-to-back pushes never glitch it.
    task automatic push(input logic [31:0] d, input logic [3:0] b);
        int n;
        tx_valid = 1'b1;
        tx_data  = d;
        tx_be_n  = b;
        n = 0;
        while (tx_ready !== 1'b1 && n < 100) begin
            @(negedge clock);
            n++;
        end
        if (n >= 100) begin
            check(1'b0, "push never accepted");
            end_sim();
        end
        @(negedge clock);
    endtask : push

    // Waits for the next strobe edge, then judges the word it times.
    task automatic expect_word(input logic [31:0] d, input logic [3:0] b, input logic x4);
        int n;
        n = 0;
        while (adstb_o[0] === last_stb && n < 40) begin
            @(negedge clock);
            n++;
        end
        if (n >= 40) begin
            check(1'b0, "strobe edge missing");
            end_sim();
        end
        last_stb = adstb_o[0];
        check(ad_o[15:0] === d[15:0] && cbe_n_o[1:0] === b[1:0], "lower lanes");
        check(ad_o[31:16] === d[31:16] && cbe_n_o[3:2] === b[3:2], "upper lanes");
        check(adstb_o[1] === adstb_o[0] && adstb_oe_n === 2'b00, "strobes driven");
        check(adstb_n_o === ~adstb_o && adstb_n_oe_n[0] === 1'b0, "strobe 0 pair");
        check(adstb_n_oe_n[1] === ~x4, "strobe 1 complement drive");
        check(ad_oe_n === `AGP_OE_ON, "bus drive");
    endtask : expect_word

    // Waits for the sequencer to release all pins.
    task automatic wait_idle();
        int n;
        n = 0;
        while (tx_busy !== 1'b0 && n < 60) begin
            @(negedge clock);
            n++;
        end
        check(n < 60, "sequencer stuck busy");
        if (n >= 60) begin
            end_sim();
        end
        check(ad_oe_n === 1'b1 && adstb_oe_n === 2'b11 && adstb_n_oe_n === 2'b11, "pins released");
        last_stb = adstb_o[0];
    endtask : wait_idle

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        check(tx_ready === 1'b1 && tx_busy === 1'b0 && sb_valid === 1'b0, "reset flags");
        check(adstb_o === 2'b00 && adstb_n_o === 2'b11 && cbe_n_o === 4'hf, "reset levels");
        check(ad_oe_n === 1'b1 && adstb_oe_n === 2'b11 && adstb_n_oe_n === 2'b11, "reset enables");
    endtask : t_reset

    // One 2x word: strobe 1 complement must stay off.
    task automatic t_single_2x();
        rate_4x   = 1'b0;
        src_grant = 1'b1;
        push(32'h1234_abcd, 4'h6);
        tx_valid = 1'b0;
        expect_word(32'h1234_abcd, 4'h6, 1'b0);
        wait_idle();
    endtask : t_single_2x

    // Fill the FIFO with no grant, then drain a back-to-back 4x burst.
    task automatic t_fill_4x();
        src_grant = 1'b0;
        rate_4x   = 1'b1;
        for (int i = 0; i < 16; i++) begin
            push({4{i[3:0], ~i[3:0]}}, i[3:0]);
        end
        tx_valid = 1'b0;
        check(tx_ready === 1'b0, "full FIFO still ready");
        check(tx_busy === 1'b0 && ad_oe_n === 1'b1, "drove without grant");
        src_grant = 1'b1;
        for (int i = 0; i < 16; i++) begin
            expect_word({4{i[3:0], ~i[3:0]}}, i[3:0], 1'b1);
        end
        wait_idle();
        check(tx_ready === 1'b1, "drained FIFO not ready");
    endtask : t_fill_4x

    // Bytes before sideband mode are dropped; after it and two flush bytes, each one arrives.
    task automatic t_sideband();
        int base;
        sb_enable = 1'b0;
        base = sb_count;
        agp_master_model_inst.send_byte(8'h5a);
        repeat (12) @(negedge clock);
        check(sb_count == base, "byte taken before sideband mode");
        sb_enable = 1'b1;
        agp_master_model_inst.send_byte(8'h00);
        agp_master_model_inst.send_byte(8'h00);
        repeat (12) @(negedge clock);
        base = sb_count;
        agp_master_model_inst.send_byte(8'h3c);
        agp_master_model_inst.send_byte(8'hc3);
        repeat (12) @(negedge clock);
        check(sb_count == base + 2, "sideband byte count");
        check(sb_addr === 8'hc3, "sideband byte value");
        check(link_clock === 1'b0 && link_clock_n === 1'b1, "sideband strobe pair idle");
    endtask : t_sideband

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    // Reset is held for five core cycles; the link side resets
    // asynchronously, so it needs no strobe while reset is low.
    initial begin
        nrst       = 1'b0;
        tx_valid   = 1'b0;
        tx_data    = 32'h0000_0000;
        tx_be_n    = 4'hf;
        src_grant  = 1'b0;
        rate_4x    = 1'b0;
        sb_enable  = 1'b0;
        last_stb   = 1'b0;
        fail_count = 0;
        compares   = 0;
        repeat (4) @(negedge clock);
        @(negedge clock);
        t_reset();
        nrst = 1'b1;
        @(negedge clock);
        t_reset();
        t_single_2x();
        t_fill_4x();
        t_single_2x();
        t_sideband();
        end_sim();
    end
endmodule : tb_agp_strobe_port

`default_nettype wire
